/* rtl/cri_defs.svh */
// Constants of the receive interrupt enable block: offsets, fields, thresholds.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CRI_DEFS_SVH
`define CRI_DEFS_SVH

`define CRI_ADDR_W      2
`define CRI_DATA_W      8
`define CRI_OFS_FLAGS   2'h0
`define CRI_OFS_ENABLES 2'h1
`define CRI_OFS_CLEAR   2'h2

`define CRI_BIT_WAKE    7
`define CRI_BIT_STAT    6
`define CRI_RX_HI       5
`define CRI_RX_LO       4
`define CRI_TX_HI       3
`define CRI_TX_LO       2
`define CRI_BIT_OVR     1
`define CRI_BIT_FULL    0

`define CRI_EN_RESET    8'h00
`define CRI_SENS_MASK   8'h3C
`define CRI_FLAG_MASK   8'hC3
`define CRI_ZERO_BYTE   8'h00

`define CRI_ST_GOOD     2'h0
`define CRI_ST_WARN     2'h1
`define CRI_ST_ERR      2'h2
`define CRI_ST_BOFF     2'h3

`define CRI_SENS_NONE   2'h0
`define CRI_SENS_BOFF   2'h1
`define CRI_SENS_ERR    2'h2
`define CRI_SENS_ALL    2'h3

`define CRI_GOOD_MAX    9'h060
`define CRI_WARN_MAX    9'h07F
`define CRI_ERR_MAX     9'h0FF

`endif

/* rtl/cri_pkg.sv */
// Types shared by the receive interrupt enable block.
// Assumes cri_defs.svh on the include path.
`include "cri_defs.svh"

package cri_pkg;

  typedef enum logic [1:0] {
    CRI_GOOD = `CRI_ST_GOOD,
    CRI_WARN = `CRI_ST_WARN,
    CRI_ERR  = `CRI_ST_ERR,
    CRI_BOFF = `CRI_ST_BOFF
  } cri_level_t;

  typedef struct packed {
    logic [7:0] enables;
    logic       wake_f;
    logic       stat_f;
    logic       ovr_f;
    logic       full_f;
    cri_level_t rx_st;
    cri_level_t tx_st;
    logic [7:0] rdata;
    logic       wake_irq;
    logic       err_irq;
    logic       rx_irq;
    logic       irq;
  } cri_regs_t;

endpackage : cri_pkg

/* rtl/cri_level_map.sv */
// Maps the error counters onto receiver and transmitter bus levels.
// Assumes counters come from logic on the same clock; purely combinational.
`timescale 1ns/1ns
`default_nettype none
`include "cri_defs.svh"

module cri_level_map #(
  parameter int REC_W = 8,
  parameter int TEC_W = 9
) (
  input  wire logic [REC_W-1:0]  rec_in,
  input  wire logic [TEC_W-1:0]  tec_in,
  output var  cri_pkg::cri_level_t rx_level_out,
  output var  cri_pkg::cri_level_t tx_level_out
);
  import cri_pkg::*;

  // Narrower counters could not reach the bus-off threshold
  if (REC_W < 8 || TEC_W < 9 || REC_W > TEC_W)
  begin : g_width_check
    $error("cri_level_map: counter widths unsupported");
  end

  logic [TEC_W-1:0] rec_wide;

  assign rec_wide = TEC_W'(rec_in);

  function automatic cri_level_t classify(input logic [TEC_W-1:0] cnt);
    if (cnt > TEC_W'(`CRI_ERR_MAX))
      classify = CRI_BOFF;
    else if (cnt > TEC_W'(`CRI_WARN_MAX))
      classify = CRI_ERR;
    else if (cnt > TEC_W'(`CRI_GOOD_MAX))
      classify = CRI_WARN;
    else
      classify = CRI_GOOD;
  endfunction : classify

  // Bus-off is a transmitter condition mirrored into the receiver code
  always_comb
  begin
    tx_level_out = classify(tec_in);
    if (tx_level_out == CRI_BOFF)
      rx_level_out = CRI_BOFF;
    else if (classify(rec_wide) == CRI_BOFF)
      rx_level_out = CRI_ERR;
    else
      rx_level_out = classify(rec_wide);
  end

endmodule : cri_level_map
`default_nettype wire

/* rtl/cri_rx_irq.sv */
// Receive interrupt enable register, receive-side flags and request lines.
// Assumes init handshake, counters and event pulses come from the same clock.
//
// Overview of operation
// - The enable register reads at any time and takes writes only with init request and acknowledge both low.
// - With init request and acknowledge both high enable bits 7, 6, 1 and 0 sit at reset value.
// - The two sensitivity fields keep their values through init mode.
// - Enable bit 7 lets a detected wake-up raise the wake-up request.
// - Enable bit 6 lets a bus status change raise the error request.
// - Bits 5-4 pick which receiver level changes set the status change flag.
// - Bits 3-2 pick, with the same coding, which transmitter changes set it.
// - The level fields track the real levels but update only with no change pending.
// - Enable bit 1 lets a receive overrun raise the error request.
// - Enable bit 0 lets a full receive buffer raise the receive request.
// - When the transmitter leaves bus-off to good, the receiver level goes good too.
// - The status change flag follows counter-driven level moves above 96, 127 and 255.
// - Each request is a level that stands while its flag and enable are set.
// - The full flag sets when a good message enters the foreground receive buffer.
`timescale 1ns/1ns
`default_nettype none
`include "cri_defs.svh"

module cri_rx_irq #(
  parameter int REC_W = 8,
  parameter int TEC_W = 9
) (
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_in,
  input  wire logic [`CRI_ADDR_W-1:0] addr_in,
  input  wire logic [7:0]             wr_data_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  input  wire logic                   init_request_in,
  input  wire logic                   init_acknowledge_in,
  input  wire logic                   wakeup_detect_enable_in,
  input  wire logic                   wakeup_event_in,
  input  wire logic                   overrun_event_in,
  input  wire logic                   rx_shift_in,
  input  wire logic [REC_W-1:0]       rec_in,
  input  wire logic [TEC_W-1:0]       tec_in,
  output logic      [7:0]             rd_data_out,
  output logic      [7:0]             receive_interrupt_enables_out,
  output logic                        status_change_flag_out,
  output logic                        rx_buffer_full_flag_out,
  output var cri_pkg::cri_level_t     rx_bus_state_out,
  output var cri_pkg::cri_level_t     tx_bus_state_out,
  output logic                        wakeup_irq_out,
  output logic                        error_irq_out,
  output logic                        rx_irq_out,
  output logic                        irq_out
);
  import cri_pkg::*;

  // Narrower counters could not reach the bus-off threshold
  if (REC_W < 8 || TEC_W < 9 || REC_W > TEC_W)
  begin : g_width_check
    $error("cri_rx_irq: counter widths unsupported");
  end

  cri_regs_t  r_reg;
  cri_regs_t  r_next;
  cri_level_t act_rx;
  cri_level_t act_tx;
  cri_level_t eff_rx;
  logic       in_init;
  logic       wr_ok;
  logic [7:0] clr;
  logic       stat_set;
  logic       wake_set;

  cri_level_map #(
    .REC_W (REC_W),
    .TEC_W (TEC_W)
  ) u_level_map (
    .rec_in       (rec_in),
    .tec_in       (tec_in),
    .rx_level_out (act_rx),
    .tx_level_out (act_tx)
  );

  // Decides whether a level move counts under a two-bit sensitivity code
  function automatic logic sensitive(
    input logic [1:0] sel,
    input cri_level_t old_l,
    input cri_level_t new_l
  );
    logic old_hi;
    logic new_hi;
    old_hi = (old_l == CRI_ERR) || (old_l == CRI_BOFF);
    new_hi = (new_l == CRI_ERR) || (new_l == CRI_BOFF);
    unique case (sel)
      `CRI_SENS_NONE: sensitive = 1'b0;
      `CRI_SENS_BOFF: sensitive = (old_l == CRI_BOFF) != (new_l == CRI_BOFF);
      `CRI_SENS_ERR:  sensitive = old_hi != new_hi;
      `CRI_SENS_ALL:  sensitive = old_l != new_l;
    endcase
  endfunction : sensitive

  always_comb
  begin
    r_next   = r_reg;
    in_init  = init_request_in && init_acknowledge_in;
    wr_ok    = wr_in && !init_request_in && !init_acknowledge_in;
    clr      = (wr_in && addr_in == `CRI_OFS_CLEAR) ? (wr_data_in & `CRI_FLAG_MASK)
                                                     : `CRI_ZERO_BYTE;
    stat_set = 1'b0;
    wake_set = wakeup_event_in && wakeup_detect_enable_in;
    eff_rx   = act_rx;

    // Enable register
    if (wr_ok && addr_in == `CRI_OFS_ENABLES)
      r_next.enables = wr_data_in;
    if (in_init)
      r_next.enables = (r_reg.enables & `CRI_SENS_MASK)
                       | (`CRI_EN_RESET & `CRI_FLAG_MASK);

    // Levels move only while no status change is pending
    if (r_reg.tx_st == CRI_BOFF && act_tx == CRI_GOOD)
      eff_rx = CRI_GOOD;
    if (!r_reg.stat_f)
    begin
      r_next.rx_st = eff_rx;
      r_next.tx_st = act_tx;
      stat_set = sensitive(r_reg.enables[`CRI_RX_HI:`CRI_RX_LO],
                           r_reg.rx_st, eff_rx)
               || sensitive(r_reg.enables[`CRI_TX_HI:`CRI_TX_LO],
                            r_reg.tx_st, act_tx);
    end

    // Sticky flags: a set in the clearing cycle wins
    r_next.wake_f = (r_reg.wake_f && !clr[`CRI_BIT_WAKE]) || wake_set;
    r_next.stat_f = (r_reg.stat_f && !clr[`CRI_BIT_STAT]) || stat_set;
    r_next.ovr_f  = (r_reg.ovr_f && !clr[`CRI_BIT_OVR]) || overrun_event_in;
    r_next.full_f = (r_reg.full_f && !clr[`CRI_BIT_FULL]) || rx_shift_in;

    // Requests from next values so they line up with the flags
    r_next.wake_irq = r_next.wake_f && r_next.enables[`CRI_BIT_WAKE];
    r_next.err_irq  = (r_next.stat_f && r_next.enables[`CRI_BIT_STAT])
                   || (r_next.ovr_f && r_next.enables[`CRI_BIT_OVR]);
    r_next.rx_irq   = r_next.full_f && r_next.enables[`CRI_BIT_FULL];
    r_next.irq      = r_next.wake_irq || r_next.err_irq || r_next.rx_irq;

    // Read data only stands in the cycle after the strobe
    r_next.rdata = `CRI_ZERO_BYTE;
    if (rd_in)
    begin
      unique case (addr_in)
        `CRI_OFS_FLAGS:   r_next.rdata = {r_reg.wake_f, r_reg.stat_f, r_reg.rx_st,
                                          r_reg.tx_st, r_reg.ovr_f, r_reg.full_f};
        `CRI_OFS_ENABLES: r_next.rdata = r_reg.enables;
        default:          r_next.rdata = `CRI_ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      r_reg         <= '0;
      r_reg.enables <= `CRI_EN_RESET;
      r_reg.rx_st   <= CRI_GOOD;
      r_reg.tx_st   <= CRI_GOOD;
    end
    else
      r_reg <= r_next;
  end

  assign rd_data_out                   = r_reg.rdata;
  assign receive_interrupt_enables_out = r_reg.enables;
  assign status_change_flag_out        = r_reg.stat_f;
  assign rx_buffer_full_flag_out       = r_reg.full_f;
  assign rx_bus_state_out              = r_reg.rx_st;
  assign tx_bus_state_out              = r_reg.tx_st;
  assign wakeup_irq_out                = r_reg.wake_irq;
  assign error_irq_out                 = r_reg.err_irq;
  assign rx_irq_out                    = r_reg.rx_irq;
  assign irq_out                       = r_reg.irq;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  init_hold_en_a: assert property (
    init_request_in && init_acknowledge_in
    |=> (receive_interrupt_enables_out & `CRI_FLAG_MASK) == `CRI_EN_RESET)
    else $error("enables not held at reset value in init mode");

  sens_kept_a: assert property (
    init_request_in && init_acknowledge_in
    |=> (receive_interrupt_enables_out & `CRI_SENS_MASK)
        == ($past(receive_interrupt_enables_out) & `CRI_SENS_MASK))
    else $error("sensitivity fields changed in init mode");

  write_blocked_a: assert property (
    wr_in && addr_in == `CRI_OFS_ENABLES && (init_request_in || init_acknowledge_in)
    |=> $stable(receive_interrupt_enables_out & `CRI_SENS_MASK))
    else $error("enable write accepted during init handshake");

  enable_write_a: assert property (
    wr_in && addr_in == `CRI_OFS_ENABLES && !init_request_in && !init_acknowledge_in
    |=> receive_interrupt_enables_out == $past(wr_data_in))
    else $error("enable write lost outside init mode");

  enable_read_a: assert property (
    rd_in && addr_in == `CRI_OFS_ENABLES
    |=> rd_data_out == $past(receive_interrupt_enables_out)
        ##1 (rd_data_out == `CRI_ZERO_BYTE || $past(rd_in)))
    else $error("enable read data wrong or not one cycle");

  wake_req_a: assert property (
    wakeup_irq_out == (r_reg.wake_f && receive_interrupt_enables_out[`CRI_BIT_WAKE]))
    else $error("wake-up request not flag and enable");

  error_req_a: assert property (
    error_irq_out == ((status_change_flag_out
                       && receive_interrupt_enables_out[`CRI_BIT_STAT])
                      || (r_reg.ovr_f && receive_interrupt_enables_out[`CRI_BIT_OVR])))
    else $error("error request not the or of its two terms");

  rx_req_a: assert property (
    rx_irq_out == (rx_buffer_full_flag_out
                   && receive_interrupt_enables_out[`CRI_BIT_FULL]))
    else $error("receive request not flag and enable");

  full_set_wins_a: assert property (
    rx_shift_in |=> rx_buffer_full_flag_out)
    else $error("full flag missed a message shift");

  level_frozen_a: assert property (
    status_change_flag_out
    |=> $stable(rx_bus_state_out) && $stable(tx_bus_state_out))
    else $error("bus levels moved while a status change is pending");

  rx_forced_good_a: assert property (
    $past(tx_bus_state_out) == CRI_BOFF && tx_bus_state_out == CRI_GOOD
    |-> rx_bus_state_out == CRI_GOOD)
    else $error("receiver level not forced good on bus-off exit");

  sens_none_a: assert property (
    !status_change_flag_out && !clr[`CRI_BIT_STAT]
    && receive_interrupt_enables_out[`CRI_RX_HI:`CRI_TX_LO] == 4'h0
    |=> !status_change_flag_out)
    else $error("status change flag set with both sensitivities off");

  irq_or_a: assert property (
    irq_out == (wakeup_irq_out || error_irq_out || rx_irq_out))
    else $error("summary request not the or of the three lines");

  wake_detect_a: assert property (
    wakeup_event_in && wakeup_detect_enable_in |=> r_reg.wake_f)
    else $error("wake-up flag missed a detected event");

  wake_gated_a: assert property (
    !r_reg.wake_f && !wakeup_detect_enable_in |=> !r_reg.wake_f)
    else $error("wake-up flag set with detection off");

  ovr_set_a: assert property (
    overrun_event_in |=> r_reg.ovr_f)
    else $error("overrun flag missed an overrun");

  full_clear_a: assert property (
    clr[`CRI_BIT_FULL] && !rx_shift_in |=> !rx_buffer_full_flag_out)
    else $error("full flag not cleared by a written one");

  read_idle_a: assert property (
    !rd_in |=> rd_data_out == `CRI_ZERO_BYTE)
    else $error("read data present without a read strobe");

  part_init_a: assert property (
    wr_in && addr_in == `CRI_OFS_ENABLES && (init_request_in != init_acknowledge_in)
    |=> $stable(receive_interrupt_enables_out))
    else $error("enable write taken during init handshake");

  boff_mirror_a: assert property (
    tx_bus_state_out == CRI_BOFF |-> rx_bus_state_out == CRI_BOFF)
    else $error("receiver level not bus-off with the transmitter");

  stat_err_req_a: assert property (
    status_change_flag_out && receive_interrupt_enables_out[`CRI_BIT_STAT]
    |-> error_irq_out)
    else $error("pending status change without error request");

  rx_all_moves_a: assert property (
    !status_change_flag_out
    && receive_interrupt_enables_out[`CRI_RX_HI:`CRI_RX_LO] == `CRI_SENS_ALL
    |=> rx_bus_state_out == $past(rx_bus_state_out) || status_change_flag_out)
    else $error("receiver level move missed under full sensitivity");

  tx_all_moves_a: assert property (
    !status_change_flag_out
    && receive_interrupt_enables_out[`CRI_TX_HI:`CRI_TX_LO] == `CRI_SENS_ALL
    |=> tx_bus_state_out == $past(tx_bus_state_out) || status_change_flag_out)
    else $error("transmitter level move missed under full sensitivity");

endmodule : cri_rx_irq
`default_nettype wire

/* tb/can_rx_irq_enable_bench.sv */
// Self-checking bench for the receive interrupt enable block.
// Assumes cri_pkg and cri_defs.svh are compiled first; the bench drives every port.
`timescale 1ns/1ns
`default_nettype none
`include "cri_defs.svh"

module can_rx_irq_enable_bench;
  import cri_pkg::*;
  logic       core_clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       ireq = 1'b0;
  logic       iack = 1'b0;
  logic       wde = 1'b0;
  logic [2:0] evs = 3'h0;
  logic [7:0] rec = 8'h00;
  logic [8:0] tec = 9'h000;
  logic [7:0] rdata, en, got, v, cur_en;
  logic       sflag, fflag, wirq, eirq, rirq, irq, lin;
  cri_level_t rxl, txl, orx, otx;
  int         error_cnt = 0;
  int         n_compared = 0;
  int         seed = 71;
  int         i;

  always #5 core_clk_in = ~core_clk_in;

  cri_rx_irq u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .init_request_in(ireq),
    .init_acknowledge_in(iack), .wakeup_detect_enable_in(wde), .wakeup_event_in(evs[2]),
    .overrun_event_in(evs[1]), .rx_shift_in(evs[0]), .rec_in(rec), .tec_in(tec),
    .rd_data_out(rdata), .receive_interrupt_enables_out(en), .status_change_flag_out(sflag),
    .rx_buffer_full_flag_out(fflag), .rx_bus_state_out(rxl), .tx_bus_state_out(txl),
    .wakeup_irq_out(wirq), .error_irq_out(eirq), .rx_irq_out(rirq), .irq_out(irq));

  function automatic cri_level_t tx_lvl(input logic [8:0] t);
    if (t > 9'h0FF) return CRI_BOFF;
    if (t > 9'h07F) return CRI_ERR;
    if (t > 9'h060) return CRI_WARN;
    return CRI_GOOD;
  endfunction : tx_lvl

  function automatic cri_level_t rx_lvl(input logic [7:0] r, input logic [8:0] t);
    if (t > 9'h0FF) return CRI_BOFF;
    if (r > 8'h7F) return CRI_ERR;
    if (r > 8'h60) return CRI_WARN;
    return CRI_GOOD;
  endfunction : rx_lvl

  function automatic logic counts(input logic [1:0] s, input cri_level_t o, input cri_level_t n);
    case (s)
      2'h0: return 1'b0;
      2'h1: return (o == CRI_BOFF) != (n == CRI_BOFF);
      2'h2: return (o >= CRI_ERR) != (n >= CRI_ERR);
      default: return o != n;
    endcase
  endfunction : counts

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // Counters held steady so each step is a single level move
  task automatic move(input logic [7:0] r, input logic [8:0] t);
    cri_level_t nrx;
    cri_level_t ntx;
    logic       e;
    nrx = rx_lvl(r, t);
    ntx = tx_lvl(t);
    e = counts(cur_en[5:4], orx, nrx) | counts(cur_en[3:2], otx, ntx);
    @(posedge core_clk_in);
    rec <= r;
    tec <= t;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk("status_flag", {7'h00, e}, {7'h00, sflag});
    chk("error_irq", {7'h00, e & cur_en[6]}, {7'h00, eirq});
    chk("rx_level", {6'h00, nrx}, {6'h00, rxl});
    chk("tx_level", {6'h00, ntx}, {6'h00, txl});
    if (e)
    begin
      @(posedge core_clk_in);
      rec <= ~r;
      repeat (2) @(posedge core_clk_in);
      #1;
      chk("frozen_rx", {6'h00, nrx}, {6'h00, rxl});
      chk("frozen_flag", 8'h01, {7'h00, sflag});
      @(posedge core_clk_in);
      rec <= r;
      wr_reg(2'h2, 8'hC3);
      repeat (2) @(posedge core_clk_in);
    end
    orx = nrx;
    otx = ntx;
  endtask : move

  initial
  begin
    orx = CRI_GOOD;
    otx = CRI_GOOD;
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    wde <= 1'b1;
    rd_reg(2'h1, got);
    chk("enables_reset", 8'h00, got);
    $display("test reset done");
    for (i = 0; i < 6; i++)
    begin
      v = 8'($random(seed));
      wr_reg(2'h1, v);
      cur_en = v;
      rd_reg(2'h1, got);
      chk("enables_read", v, got);
    end
    wr_reg(2'h3, ~cur_en);
    rd_reg(2'h3, got);
    chk("unmapped_read", 8'h00, got);
    chk("enables_kept", cur_en, en);
    $display("test register done");
    @(posedge core_clk_in);
    ireq <= 1'b1;
    wr_reg(2'h1, ~cur_en);
    iack <= 1'b1;
    #1;
    chk("write_in_request", cur_en, en);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk("init_hold", cur_en & 8'h3C, en);
    wr_reg(2'h1, 8'hFF);
    ireq <= 1'b0;
    iack <= 1'b0;
    #1;
    chk("init_sens_kept", cur_en & 8'h3C, en);
    $display("test init done");
    for (i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 8'h80 : ((i == 1) ? 8'h02 : 8'h01);
      wr_reg(2'h1, v);
      @(posedge core_clk_in);
      evs <= 3'h4 >> i;
      @(posedge core_clk_in);
      evs <= 3'h0;
      #1;
      lin = (i == 0) ? wirq : ((i == 1) ? eirq : rirq);
      chk("irq_line", 8'h01, {7'h00, lin});
      chk("irq_any", 8'h01, {7'h00, irq});
      chk("full_flag", {7'h00, i == 2}, {7'h00, fflag});
      wr_reg(2'h1, 8'h00);
      repeat (2) @(posedge core_clk_in);
      #1;
      chk("irq_masked", 8'h00, {7'h00, irq});
      rd_reg(2'h0, got);
      chk("flag_sticky", v, got & 8'hC3);
      wr_reg(2'h2, v);
      rd_reg(2'h0, got);
      chk("flag_cleared", 8'h00, got & 8'hC3);
    end
    @(posedge core_clk_in);
    wde <= 1'b0;
    evs <= 3'h4;
    @(posedge core_clk_in);
    evs <= 3'h0;
    rd_reg(2'h0, got);
    chk("wake_no_detect", 8'h00, got & 8'h80);
    wde <= 1'b1;
    $display("test events done");
    for (i = 0; i < 16; i++)
    begin
      // Status enable kept on so the error line follows the flag
      cur_en = 8'h40 | {2'h0, 4'(i), 2'h0};
      wr_reg(2'h1, cur_en);
      move(8'($random(seed)), {1'b0, 8'($random(seed))});
      move(8'h60, 9'h060);
      move(8'h80, 9'h0FF);
      move(8'h61, 9'h080);
    end
    $display("test sensitivity done");
    cur_en = 8'h7C;
    wr_reg(2'h1, cur_en);
    move(8'hC8, 9'h12C);
    tec <= 9'h000;
    repeat (3) @(posedge core_clk_in);
    #1;
    chk("rx_forced_good", {6'h00, CRI_GOOD}, {6'h00, rxl});
    chk("tx_good", {6'h00, CRI_GOOD}, {6'h00, txl});
    $display("test bus-off exit done");
    stop_test();
  end

  // Tests take under a thousand cycles; this is ample margin
  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule : can_rx_irq_enable_bench
`default_nettype wire
